//--- rtl/cksr_consts.svh
// constants for the clock source, pll and reset control block
// assumes inclusion by bare name from rtl files
`ifndef CKSR_CONSTS_SVH
`define CKSR_CONSTS_SVH
`define CKSR_CLK_MHZ 25
`define CKSR_RST_PULSE_NS 50
// samples that a pulse of the least width is sure to span: rounds down, never below one
`define CKSR_RST_PULSE_CYC (((`CKSR_RST_PULSE_NS * `CKSR_CLK_MHZ) >= 1000) ? ((`CKSR_RST_PULSE_NS * `CKSR_CLK_MHZ) / 1000) : 1)
`define CKSR_IRC_KHZ 12000
`define CKSR_XTAL_MIN_KHZ 1000
`define CKSR_XTAL_MAX_KHZ 25000
`define CKSR_PLL_REF_MIN_KHZ 10000
`define CKSR_PLL_REF_MAX_KHZ 25000
`define CKSR_CCO_MIN_KHZ 156000
`define CKSR_CCO_MAX_KHZ 320000
`define CKSR_WDO_MIN_HZ 9400
`define CKSR_WDO_MAX_HZ 2300000
`define CKSR_LPO_KHZ 10
`define CKSR_MULT_MIN 1
`define CKSR_MULT_MAX 32
`define CKSR_RST_STRETCH 8'h10
// register offsets
`define CKSR_REG_CLKSEL 4'h0
`define CKSR_REG_PLLCFG 4'h1
`define CKSR_REG_PLLSRC 4'h2
`define CKSR_REG_WDOCFG 4'h3
`define CKSR_REG_LPOCFG 4'h4
`define CKSR_REG_BODCFG 4'h5
`define CKSR_REG_STATUS 4'h6
`define CKSR_REG_IRQ_STAT 4'h7
`define CKSR_REG_IRQ_MASK 4'h8
`define CKSR_REG_RSTSRC 4'h9
// irq bit positions
`define CKSR_IRQ_BOD 0
`define CKSR_IRQ_LOCK 1
`define CKSR_IRQ_SWREJ 2
`endif

//--- rtl/cksr_pkg.sv
// types for the clock source, pll and reset control block
// assumes cksr_consts.svh is compiled alongside
package cksr_pkg;
    typedef enum logic [1:0] {CKSR_SRC_IRC = 2'h0, CKSR_SRC_PLL_IN = 2'h1, CKSR_SRC_PLL_OUT = 2'h3,
        CKSR_SRC_XTAL = 2'h2} cksr_src_e;
    typedef enum logic [1:0] {CKSR_PSRC_IRC = 2'h0, CKSR_PSRC_XTAL = 2'h1, CKSR_PSRC_EXT = 2'h3,
        CKSR_PSRC_RSV = 2'h2} cksr_psrc_e;
    typedef enum logic [1:0] {CKSR_SW_IDLE = 2'h0, CKSR_SW_OFF = 2'h1, CKSR_SW_ON = 2'h3} cksr_sw_e;
    typedef struct packed {
        logic [1:0] sel_req;
        logic [1:0] sel_cur;
        cksr_sw_e sw_st;
        logic [1:0] psrc;
        logic [4:0] msel;
        logic [1:0] psel;
        logic pll_pd;
        logic [8:0] wdo_cfg;
        logic lpo_en;
        logic lpo_run_lp;
        logic [1:0] bod_irq_lvl;
        logic [1:0] bod_rst_lvl;
        logic bod_rst_en;
        logic [2:0] irq_stat;
        logic [2:0] irq_mask;
        logic [3:0] rst_src;
        logic [7:0] rst_cnt;
        logic [1:0] pin_lo_cnt;
        logic [1:0] rst_pin_sy;
        logic [1:0] lock_sy;
        logic lock_d;
        logic [1:0] bod_sy;
        logic bod_d;
        logic [1:0] wdt_sy;
        logic [1:0] por_sy;
        logic [15:0] rdata;
        logic irq;
        logic chip_rst_n;
        logic irc_en;
        logic flash_init;
        logic [3:0] gate;
    } cksr_st_s;
endpackage

//--- rtl/cksr_top.sv
// clock source selection, system pll control, chip reset and brownout logic
// assumes: oscillators, pll, clock gates and supply monitor are analog macros outside;
// register port is a plain strobe port on the same clock; async pins but bod_rst_det are synchronised here
//
// Function
// [RULE_01] after any reset the internal rc oscillator is the selected main clock
// [RULE_02] rc oscillator nominal 12 mhz feeds watchdog, cpu directly, or the pll
// [RULE_03] crystal oscillator 1 to 25 mhz feeds cpu directly or through the pll
// [RULE_04] watchdog oscillator frequency programmable 9.4 khz to 2.3 mhz for watchdog
// [RULE_05] low-power 10 khz oscillator clocks wake-up timer, may run in low-power modes
// [RULE_06] all oscillators but low-frequency one route to several consumers
// [RULE_07] external clock on clock or crystal pin stays at or below 25 mhz
// [RULE_08] pll reference lies between 10 and 25 mhz; software picks such source
// [RULE_09] pll feedback multiplier accepts every integer 1 through 32
// [RULE_10] cco stays 156 to 320 mhz by a loop post divider
// [RULE_11] chip reset from pin, watchdog, power-on and brownout sources
// [RULE_12] any chip reset starts rc oscillator and initialises flash controller
// [RULE_13] a low pulse of 50 ns or longer on reset pin resets device
// [RULE_14] on reset release registers hold defaults and fetch starts at address zero
// [RULE_15] supply below chosen brownout level raises interrupt, also pollable in status
// [RULE_16] four selectable brownout reset levels, chosen apart from interrupt level
// [RULE_17] main clock switch between rc, crystal and pll is glitch free
// [RULE_18] pll output not taken as main clock until pll reports lock
//
// The plain strobed port and the address map were chosen for this implementation.
`timescale 1ns/100ps
`include "cksr_consts.svh"
module cksr_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic rst_pin_n,
    input wire logic wdt_rst,
    input wire logic pll_lock,
    input wire logic bod_irq_det,
    input wire logic bod_rst_det,
    input wire logic [3:0] addr,
    input wire logic [15:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [15:0] rdata,
    output logic irq,
    output logic chip_rst_n,
    output logic irc_en,
    output logic flash_init,
    output logic [3:0] main_clk_gate,
    output logic [1:0] pll_src_sel,
    output logic [4:0] pll_msel,
    output logic [1:0] pll_psel,
    output logic pll_pd,
    output logic [8:0] wdo_cfg,
    output logic lpo_en,
    output logic lpo_run_lp,
    output logic [1:0] bod_irq_lvl,
    output logic [1:0] bod_rst_lvl,
    output logic boot_vector_zero
);
    // ====================================================
    // reset release
    logic [1:0] rst_sync_r;
    logic rst_n_i;
    cksr_pkg::cksr_st_s st_r;
    cksr_pkg::cksr_st_s st_nxt;

    // two-stage release of the async reset
    always_ff @(posedge clock or negedge reset_n)
    begin
        if (!reset_n)
            rst_sync_r <= 2'h0;
        else
            rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
    assign rst_n_i = rst_sync_r[1];

    // ====================================================
    // helpers
    // one-hot gate enable for a main clock source code
    function automatic logic [3:0] src_gate(input logic [1:0] s);
        src_gate = 4'h1 << s;
    endfunction

    // register index match
    function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
        hit = (a == off);
    endfunction

    // ====================================================
    // next state
    always_comb
    begin
        st_nxt = st_r;
        // synchronisers: first stage read only by the second
        st_nxt.rst_pin_sy = {st_r.rst_pin_sy[0], rst_pin_n};
        st_nxt.lock_sy = {st_r.lock_sy[0], pll_lock};
        st_nxt.bod_sy = {st_r.bod_sy[0], bod_irq_det};
        st_nxt.wdt_sy = {st_r.wdt_sy[0], wdt_rst};
        st_nxt.por_sy = {st_r.por_sy[0], por_n};
        st_nxt.lock_d = st_r.lock_sy[1];
        st_nxt.bod_d = st_r.bod_sy[1];

        // reset pin low counter: a 50 ns pulse always spans at least one 40 ns sample
        if (!st_r.rst_pin_sy[1])
        begin
            if (st_r.pin_lo_cnt != 2'h3)
                st_nxt.pin_lo_cnt = st_r.pin_lo_cnt + 2'h1;
        end
        else
            st_nxt.pin_lo_cnt = 2'h0;

        // chip reset sources and stretch
        if (st_r.pin_lo_cnt >= 2'(`CKSR_RST_PULSE_CYC)) // RULE_13
        begin
            st_nxt.rst_src[0] = 1'b1; // RULE_11
            st_nxt.rst_cnt = `CKSR_RST_STRETCH;
        end
        if (st_r.wdt_sy[1])
        begin
            st_nxt.rst_src[1] = 1'b1; // RULE_11
            st_nxt.rst_cnt = `CKSR_RST_STRETCH;
        end
        if (!st_r.por_sy[1])
        begin
            st_nxt.rst_src[2] = 1'b1; // RULE_11
            st_nxt.rst_cnt = `CKSR_RST_STRETCH;
        end
        if (bod_rst_det && st_r.bod_rst_en)
        begin
            st_nxt.rst_src[3] = 1'b1; // RULE_16
            st_nxt.rst_cnt = `CKSR_RST_STRETCH;
        end

        if (st_nxt.rst_cnt != 8'h00)
        begin
            // chip held: defaults restored, rc on, flash init
            st_nxt.chip_rst_n = 1'b0; // RULE_14
            st_nxt.irc_en = 1'b1; // RULE_12
            st_nxt.flash_init = 1'b1; // RULE_12
            st_nxt.sel_req = cksr_pkg::CKSR_SRC_IRC; // RULE_01
            st_nxt.sel_cur = cksr_pkg::CKSR_SRC_IRC; // RULE_01
            st_nxt.sw_st = cksr_pkg::CKSR_SW_IDLE;
            st_nxt.gate = src_gate(cksr_pkg::CKSR_SRC_IRC);
            st_nxt.psrc = cksr_pkg::CKSR_PSRC_IRC;
            st_nxt.msel = 5'h00;
            st_nxt.psel = 2'h0;
            st_nxt.pll_pd = 1'b1;
            st_nxt.irq_mask = 3'h0;
            st_nxt.irq_stat = 3'h0;
            st_nxt.wdo_cfg = 9'h000; // RULE_14
            st_nxt.lpo_en = 1'b1; // RULE_14
            st_nxt.lpo_run_lp = 1'b0;
            st_nxt.bod_irq_lvl = 2'h0;
            st_nxt.bod_rst_lvl = 2'h0;
            st_nxt.bod_rst_en = 1'b0;
            if (st_r.rst_cnt != 8'h00)
                st_nxt.rst_cnt = st_r.rst_cnt - 8'h01;
        end
        else
        begin
            st_nxt.chip_rst_n = 1'b1;
            st_nxt.flash_init = 1'b0;

            // sticky events, set beats the write-one clear
            if (wr_stb && hit(addr, `CKSR_REG_IRQ_STAT))
                st_nxt.irq_stat = st_r.irq_stat & ~wdata[2:0];
            if (st_r.bod_sy[1] && !st_r.bod_d)
                st_nxt.irq_stat[`CKSR_IRQ_BOD] = 1'b1; // RULE_15
            if (st_r.lock_sy[1] && !st_r.lock_d)
                st_nxt.irq_stat[`CKSR_IRQ_LOCK] = 1'b1;

            // register writes
            if (wr_stb)
            begin
                if (hit(addr, `CKSR_REG_CLKSEL))
                begin
                    if (wdata[1:0] == cksr_pkg::CKSR_SRC_PLL_OUT && !st_r.lock_sy[1])
                        st_nxt.irq_stat[`CKSR_IRQ_SWREJ] = 1'b1; // RULE_18
                    else if (wdata[1:0] != cksr_pkg::CKSR_SRC_PLL_IN)
                        st_nxt.sel_req = wdata[1:0]; // RULE_17
                end
                if (hit(addr, `CKSR_REG_PLLCFG))
                begin
                    st_nxt.msel = wdata[4:0]; // RULE_09
                    st_nxt.psel = wdata[6:5]; // RULE_10
                    st_nxt.pll_pd = wdata[7];
                end
                if (hit(addr, `CKSR_REG_PLLSRC))
                    st_nxt.psrc = wdata[1:0]; // RULE_02 RULE_03 RULE_08
                if (hit(addr, `CKSR_REG_WDOCFG))
                    st_nxt.wdo_cfg = wdata[8:0]; // RULE_04
                if (hit(addr, `CKSR_REG_LPOCFG))
                begin
                    st_nxt.lpo_en = wdata[0]; // RULE_05
                    st_nxt.lpo_run_lp = wdata[1]; // RULE_05
                end
                if (hit(addr, `CKSR_REG_BODCFG))
                begin
                    st_nxt.bod_irq_lvl = wdata[1:0]; // RULE_15
                    st_nxt.bod_rst_lvl = wdata[3:2]; // RULE_16
                    st_nxt.bod_rst_en = wdata[4];
                end
                if (hit(addr, `CKSR_REG_IRQ_MASK))
                    st_nxt.irq_mask = wdata[2:0];
                if (hit(addr, `CKSR_REG_RSTSRC))
                    st_nxt.rst_src = st_r.rst_src & ~wdata[3:0];
            end

            // glitch-free switch: gate all off for two cycles, then new on
            unique case (st_r.sw_st)
                cksr_pkg::CKSR_SW_IDLE:
                begin
                    if (st_r.sel_req != st_r.sel_cur)
                    begin
                        st_nxt.gate = 4'h0; // RULE_17
                        st_nxt.sw_st = cksr_pkg::CKSR_SW_OFF;
                    end
                end
                cksr_pkg::CKSR_SW_OFF:
                begin
                    st_nxt.sel_cur = st_r.sel_req;
                    st_nxt.sw_st = cksr_pkg::CKSR_SW_ON;
                end
                cksr_pkg::CKSR_SW_ON:
                begin
                    st_nxt.gate = src_gate(st_r.sel_cur); // RULE_17
                    st_nxt.sw_st = cksr_pkg::CKSR_SW_IDLE;
                end
                default:
                    st_nxt.sw_st = cksr_pkg::CKSR_SW_IDLE;
            endcase
            // lost lock while on pll output falls back to rc
            if (st_r.sel_cur == cksr_pkg::CKSR_SRC_PLL_OUT && !st_r.lock_sy[1]
                && st_r.sw_st == cksr_pkg::CKSR_SW_IDLE)
                st_nxt.sel_req = cksr_pkg::CKSR_SRC_IRC; // RULE_18
        end

        // read data, one cycle after the strobe
        st_nxt.rdata = 16'h0000;
        if (rd_stb)
        begin
            unique case (addr)
                `CKSR_REG_CLKSEL: st_nxt.rdata = {14'h0000, st_r.sel_cur};
                `CKSR_REG_PLLCFG: st_nxt.rdata = {8'h00, st_r.pll_pd, st_r.psel, st_r.msel};
                `CKSR_REG_PLLSRC: st_nxt.rdata = {14'h0000, st_r.psrc};
                `CKSR_REG_WDOCFG: st_nxt.rdata = {7'h00, st_r.wdo_cfg};
                `CKSR_REG_LPOCFG: st_nxt.rdata = {14'h0000, st_r.lpo_run_lp, st_r.lpo_en};
                `CKSR_REG_BODCFG: st_nxt.rdata = {11'h000, st_r.bod_rst_en, st_r.bod_rst_lvl,
                    st_r.bod_irq_lvl};
                `CKSR_REG_STATUS: st_nxt.rdata = {12'h000, (st_r.sw_st != cksr_pkg::CKSR_SW_IDLE),
                    st_r.lock_sy[1], st_r.bod_sy[1], 1'b0}; // RULE_15
                `CKSR_REG_IRQ_STAT: st_nxt.rdata = {13'h0000, st_r.irq_stat};
                `CKSR_REG_IRQ_MASK: st_nxt.rdata = {13'h0000, st_r.irq_mask};
                `CKSR_REG_RSTSRC: st_nxt.rdata = {12'h000, st_r.rst_src};
                default: st_nxt.rdata = 16'h0000;
            endcase
        end
        st_nxt.irq = |(st_nxt.irq_stat & st_nxt.irq_mask); // RULE_15
    end

    // ====================================================
    // state register
    always_ff @(posedge clock or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            st_r <= '0;
            st_r.sw_st <= cksr_pkg::CKSR_SW_IDLE;
            st_r.gate <= 4'h1;
            st_r.pll_pd <= 1'b1;
            st_r.irc_en <= 1'b1; // RULE_12
            st_r.flash_init <= 1'b1;
            st_r.rst_cnt <= `CKSR_RST_STRETCH;
            st_r.rst_src <= 4'h4;
            st_r.rst_pin_sy <= 2'h3;
            st_r.por_sy <= 2'h3;
            st_r.lpo_en <= 1'b1;
        end
        else
            st_r <= st_nxt;
    end

    // ====================================================
    // outputs, all from flops
    assign rdata = st_r.rdata;
    assign irq = st_r.irq;
    assign chip_rst_n = st_r.chip_rst_n; // RULE_14
    assign irc_en = st_r.irc_en;
    assign flash_init = st_r.flash_init;
    assign main_clk_gate = st_r.gate; // RULE_06
    assign pll_src_sel = st_r.psrc;
    assign pll_msel = st_r.msel;
    assign pll_psel = st_r.psel;
    assign pll_pd = st_r.pll_pd;
    assign wdo_cfg = st_r.wdo_cfg;
    assign lpo_en = st_r.lpo_en;
    assign lpo_run_lp = st_r.lpo_run_lp;
    assign bod_irq_lvl = st_r.bod_irq_lvl;
    assign bod_rst_lvl = st_r.bod_rst_lvl;
    assign boot_vector_zero = st_r.flash_init; // RULE_14
endmodule

//--- sim/cksr_ext_model.sv
// far side model: reset sources, supply monitor and a pll that locks after a delay
// assumes the bench calls pulse and drives kill and bod_irq_det hierarchically
`timescale 1ns/100ps
module cksr_ext_model #(parameter int LOCK_CYC = 10) (
    input wire logic clock,
    input wire logic pll_pd,
    input wire logic [1:0] pll_src_sel,
    output logic por_n,
    output logic rst_pin_n,
    output logic wdt_rst,
    output logic pll_lock,
    output logic bod_irq_det,
    output logic bod_rst_det
);
    logic kill = 1'b0;
    int cnt = 0;
    initial
    begin
        por_n = 1'b1;
        rst_pin_n = 1'b1;
        wdt_rst = 1'b0;
        bod_irq_det = 1'b0;
        bod_rst_det = 1'b0;
    end
    // ========
    // pll lock: only powered and fed from an in-range reference
    always @(posedge clock)
    begin
        if (pll_pd || kill || pll_src_sel == 2'h2)
            cnt <= 0;
        else if (cnt < LOCK_CYC)
            cnt <= cnt + 1;
    end
    assign pll_lock = (cnt == LOCK_CYC);
    // ========
    // one reset source active for n cycles: 0 pin, 1 watchdog, 2 power on, 3 brownout
    task pulse(input int k, input int n);
        @(posedge clock);
        case (k)
            0: rst_pin_n <= 1'b0;
            1: wdt_rst <= 1'b1;
            2: por_n <= 1'b0;
            default: bod_rst_det <= 1'b1;
        endcase
        repeat (n) @(posedge clock);
        rst_pin_n <= 1'b1;
        wdt_rst <= 1'b0;
        por_n <= 1'b1;
        bod_rst_det <= 1'b0;
    endtask
endmodule

//--- sim/cksr_top_asserts.sv
// checker for the clock source, pll and reset control block
// assumes it is bound to cksr_top and sees only that module's ports
`timescale 1ns/100ps
module cksr_chk (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic por_n,
    input wire logic rst_pin_n,
    input wire logic wdt_rst,
    input wire logic pll_lock,
    input wire logic [3:0] addr,
    input wire logic wr_stb,
    input wire logic chip_rst_n,
    input wire logic irc_en,
    input wire logic flash_init,
    input wire logic [3:0] main_clk_gate,
    input wire logic [4:0] pll_msel,
    input wire logic boot_vector_zero
);
    // ========
    // reset and clock selection properties
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    sequence s_pin_low; !rst_pin_n [*2]; endsequence
    sequence s_held; !chip_rst_n ##1 !chip_rst_n; endsequence
    property p_rc; $rose(chip_rst_n) |-> main_clk_gate == 4'h1 && !flash_init && !boot_vector_zero; endproperty
    property p_held; s_held |-> flash_init && boot_vector_zero && irc_en; endproperty
    property p_pin; s_pin_low |-> ##[0:8] !chip_rst_n; endproperty
    property p_wdt; wdt_rst [*3] |-> ##[0:6] !chip_rst_n; endproperty
    property p_por; !por_n [*3] |-> ##[0:6] !chip_rst_n; endproperty
    // a new source is only gated on after a cycle with every gate shut
    property p_gap; chip_rst_n && $changed(main_clk_gate) && main_clk_gate != 4'h0 |-> $past(main_clk_gate) == 4'h0;
    endproperty
    property p_lock_gate; !pll_lock [*8] |-> !main_clk_gate[3]; endproperty
    property p_lock_rise; $rose(main_clk_gate[3]) |-> $past(pll_lock, 3); endproperty
    property p_msel; chip_rst_n && $past(chip_rst_n) && $changed(pll_msel) |-> $past(wr_stb) && $past(addr) == 4'h1;
    endproperty
    a_rc: assert property (p_rc) else $error("rc clock not selected at reset release");
    a_held: assert property (p_held) else $error("flash init or boot vector low in reset");
    a_pin: assert property (p_pin) else $error("short pin pulse gave no reset");
    a_wdt: assert property (p_wdt) else $error("watchdog gave no reset");
    a_por: assert property (p_por) else $error("power on gave no reset");
    a_gap: assert property (p_gap) else $error("clock switch without gap");
    a_lock_gate: assert property (p_lock_gate) else $error("pll gated without lock");
    a_lock_rise: assert property (p_lock_rise) else $error("pll taken before lock");
    a_msel: assert property (p_msel) else $error("multiplier changed without write");
endmodule
bind cksr_top cksr_chk u_chk (.clock, .reset_n, .por_n, .rst_pin_n, .wdt_rst, .pll_lock, .addr, .wr_stb,
    .chip_rst_n, .irc_en, .flash_init, .main_clk_gate, .pll_msel, .boot_vector_zero);

//--- sim/clock_source_pll_reset_control_tb.sv
// self-checking bench for the clock source, pll and reset control block
// assumes cksr_top, the far side model and the bound checker are compiled first
`timescale 1ns/100ps
`include "cksr_consts.svh"
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("mismatch t=%0t got %h exp %h", $time, g, e); end end
`define WAITFOR(c) begin for (int w = 0; w < 200 && !(c); w++) begin @(posedge clock); #1; end \
    if (!(c)) begin n_errors++; print_verdict; end end
module clock_source_pll_reset_control_tb;
    logic clock, reset_n, wr_stb, rd_stb, por_n, rst_pin_n, wdt_rst, pll_lock, bod_irq_det, bod_rst_det;
    logic irq, chip_rst_n, irc_en, flash_init, pll_pd, lpo_en, lpo_run_lp, boot_vector_zero;
    logic [3:0] addr, main_clk_gate;
    logic [15:0] wdata, rdata;
    logic [1:0] pll_src_sel, pll_psel, bod_irq_lvl, bod_rst_lvl;
    logic [4:0] pll_msel;
    logic [8:0] wdo_cfg;
    int n_errors = 0;
    int n_compared = 0;
    cksr_top dut (.clock, .reset_n, .por_n, .rst_pin_n, .wdt_rst, .pll_lock, .bod_irq_det, .bod_rst_det, .addr,
        .wdata, .wr_stb, .rd_stb, .rdata, .irq, .chip_rst_n, .irc_en, .flash_init, .main_clk_gate, .pll_src_sel,
        .pll_msel, .pll_psel, .pll_pd, .wdo_cfg, .lpo_en, .lpo_run_lp, .bod_irq_lvl, .bod_rst_lvl, .boot_vector_zero);
    cksr_ext_model far (.clock, .pll_pd, .pll_src_sel, .por_n, .rst_pin_n, .wdt_rst, .pll_lock, .bod_irq_det,
        .bod_rst_det);
    // ========
    // bus cycles
    task wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clock);
        wr_stb <= 1'b0;
    endtask
    task rd(input logic [3:0] a, input logic [15:0] e);
        @(posedge clock);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clock);
        rd_stb <= 1'b0;
        #1;
        `CHK(rdata, e)
    endtask
    task cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // ========
    // scenarios
    task t_config;
        logic [1:0] srcs [3];
        srcs = '{2'h0, 2'h1, 2'h3};
        wr(`CKSR_REG_PLLCFG, 16'h00ff);
        cyc(1);
        `CHK({pll_pd, pll_psel, pll_msel}, 8'hff)
        wr(`CKSR_REG_WDOCFG, 16'h01a5);
        rd(`CKSR_REG_WDOCFG, 16'h01a5);
        `CHK(wdo_cfg, 9'h1a5)
        wr(`CKSR_REG_LPOCFG, 16'h0003);
        cyc(1);
        `CHK({lpo_en, lpo_run_lp}, 2'h3)
        for (int i = 0; i < 4; i++)
        begin
            wr(`CKSR_REG_BODCFG, {12'h000, 2'(3 - i), 2'(i)});
            cyc(1);
            `CHK({bod_rst_lvl, bod_irq_lvl}, {2'(3 - i), 2'(i)})
        end
        foreach (srcs[j])
        begin
            wr(`CKSR_REG_PLLSRC, {14'h0000, srcs[j]});
            cyc(1);
            `CHK(pll_src_sel, srcs[j])
        end
        wr(`CKSR_REG_PLLCFG, 16'h0080);
    endtask
    task t_switch;
        wr(`CKSR_REG_IRQ_STAT, 16'h0007);
        wr(`CKSR_REG_IRQ_MASK, 16'h0004);
        wr(`CKSR_REG_CLKSEL, 16'h0003);
        cyc(6);
        `CHK({main_clk_gate, irq}, 5'h03)
        rd(`CKSR_REG_IRQ_STAT, 16'h0004);
        wr(`CKSR_REG_IRQ_STAT, 16'h0004);
        cyc(2);
        `CHK(irq, 1'b0)
        wr(`CKSR_REG_CLKSEL, 16'h0002);
        `WAITFOR(main_clk_gate === 4'h4)
        wr(`CKSR_REG_PLLSRC, 16'h0001);
        wr(`CKSR_REG_PLLCFG, 16'h0003);
        `WAITFOR(pll_lock === 1'b1)
        cyc(2);
        rd(`CKSR_REG_STATUS, 16'h0004);
        rd(`CKSR_REG_IRQ_STAT, 16'h0002);
        wr(`CKSR_REG_CLKSEL, 16'h0003);
        `WAITFOR(main_clk_gate === 4'h8)
        `CHK(main_clk_gate, 4'h8)
        far.kill <= 1'b1;
        `WAITFOR(main_clk_gate === 4'h1)
        `CHK(main_clk_gate, 4'h1)
        wr(`CKSR_REG_CLKSEL, 16'h0001);
        cyc(4);
        rd(`CKSR_REG_CLKSEL, 16'h0000);
        `CHK(main_clk_gate, 4'h1)
        far.kill <= 1'b0;
    endtask
    task t_bod;
        wr(`CKSR_REG_PLLCFG, 16'h0080);
        wr(`CKSR_REG_IRQ_STAT, 16'h0007);
        wr(`CKSR_REG_IRQ_MASK, 16'h0001);
        far.bod_irq_det <= 1'b1;
        cyc(6);
        `CHK(irq, 1'b1)
        rd(`CKSR_REG_STATUS, 16'h0002);
        far.bod_irq_det <= 1'b0;
        wr(`CKSR_REG_IRQ_STAT, 16'h0001);
        cyc(3);
        `CHK(irq, 1'b0)
    endtask
    // each reset source in turn; registers must be back at defaults afterwards
    task t_resets;
        for (int k = 0; k < 4; k++)
        begin
            wr(`CKSR_REG_RSTSRC, 16'h000f);
            wr(`CKSR_REG_PLLCFG, 16'h009f);
            wr(`CKSR_REG_BODCFG, 16'h0010);
            far.pulse(k, (k == 0) ? 2 : 4);
            `WAITFOR(chip_rst_n === 1'b0)
            cyc(2);
            `CHK({irc_en, flash_init, boot_vector_zero}, 3'h7)
            `WAITFOR(chip_rst_n === 1'b1)
            `CHK({main_clk_gate, pll_msel, pll_pd}, 10'h041)
            `CHK({wdo_cfg, lpo_en, lpo_run_lp}, 11'h002)
            rd(`CKSR_REG_RSTSRC, 16'(1 << k));
        end
    endtask
    task print_verdict;
        if (n_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // ========
    // clock, watchdog on the run and main sequence
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        repeat (100000) @(posedge clock);
        n_errors++;
        print_verdict;
    end
    initial
    begin
        reset_n = 1'b0;
        addr = 4'h0;
        wdata = 16'h0000;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        repeat (16) @(posedge clock);
        reset_n <= 1'b1;
        `WAITFOR(chip_rst_n === 1'b1)
        `CHK({main_clk_gate, irc_en, flash_init, boot_vector_zero, pll_pd, lpo_en}, 9'h033)
        rd(`CKSR_REG_RSTSRC, 16'h0004);
        rd(4'hf, 16'h0000);
        t_config;
        t_switch;
        t_bod;
        t_resets;
        print_verdict;
    end
endmodule
